// ### hw/eirc_top.sv
`timescale 1ns/1ps
`include "eirc_params.svh"
// Contract
// - With its sense bit at 0 an input is level sensitive, requesting while held low.
// - With its sense bit at 1 a high-to-low change of the input sets its flag.
// - With its sense bit at 0 a low input sets its flag; inputs are numbered 5 to 0.
// - Software clears a flag only by reading it as 1 and then writing 0 to it.
// - In level mode a flag clears itself while its exception runs and the input is high.
// - In edge mode a flag clears itself while its exception runs.
// - Writes to flags can only clear: 0 clears a flag last read as 1, 1 leaves the flag alone.
// - Each input has an enable bit, 1 permits and 0 blocks, all reset to 0.
// - Priority A bits 7..0 cover input 0, 1, 2/3, 4/5, watchdog/converter, timers 0..2.
// - Priority B bits 7,6,3,2 cover 8-bit timers 0/1, 2/3 and serial 0, 1; others unused.
module eirc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [21:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External request pins, active low
	input wire logic [5:0] ext_req_n,
	// On-chip sources, ids 6 to 13
	input wire logic [7:0] periph_req,
	// Exception handling in the core
	input wire logic exc_busy,
	input wire eirc_pkg::eirc_src_t exc_src,
	// Request to the core and event interrupt
	output logic int_req,
	output eirc_pkg::eirc_src_t int_src,
	output logic int_hi,
	output logic irq
);
	import eirc_pkg::*;

	logic rst_s1_q, rst_n_q;
	eirc_ext_t s1_q, s2_q, s3_q, lvl_q, old_q, lvl_d;
	eirc_ext_t sense_q, sense_d, en_q, en_d, flag_q, flag_d, seen_q, seen_d;
	eirc_ext_t evt_q, evt_d, mask_q, mask_d;
	eirc_reg_t pa_q, pa_d, pb_q, pb_d;
	eirc_ext_t set_vec, auto_clr, sw_clr, clr_vec;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, setup, acc, wr_acc;
	eirc_sel_t sel;
	eirc_pend_t pend;
	logic req_d, hi_d, irq_d;
	eirc_src_t src_d;

	// Word decode, shared by read setup and write access
	function automatic eirc_sel_t dec(input logic [19:0] idx);
		case (idx)
			`EIRC_IDX_SENSE: dec = EIRC_SEL_SENSE;
			`EIRC_IDX_ENABLE: dec = EIRC_SEL_ENABLE;
			`EIRC_IDX_FLAGS: dec = EIRC_SEL_FLAGS;
			`EIRC_IDX_PRI_A: dec = EIRC_SEL_PRI_A;
			`EIRC_IDX_PRI_B: dec = EIRC_SEL_PRI_B;
			`EIRC_IDX_EVT: dec = EIRC_SEL_EVT;
			`EIRC_IDX_MASK: dec = EIRC_SEL_MASK;
			default: dec = EIRC_SEL_NONE;
		endcase
	endfunction

	// Priority bit that governs each source id
	function automatic logic pri_of(input int id, input eirc_reg_t a, input eirc_reg_t b);
		case (id)
			0: pri_of = a[7];
			1: pri_of = a[6];
			2, 3: pri_of = a[5];
			4, 5: pri_of = a[4];
			6: pri_of = a[3];
			7: pri_of = a[2];
			8: pri_of = a[1];
			9: pri_of = a[0];
			10: pri_of = b[7];
			11: pri_of = b[6];
			12: pri_of = b[3];
			13: pri_of = b[2];
			default: pri_of = 1'b0;
		endcase
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Pin level follows once second and third stage agree, so glitches are ignored
	always_comb
	begin
		lvl_d = lvl_q;
		for (int i = 0; i < `EIRC_N_EXT; i++)
			if (s2_q[i] == s3_q[i])
				lvl_d[i] = s3_q[i];
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s1_q <= 6'h3f;
			s2_q <= 6'h3f;
			s3_q <= 6'h3f;
			lvl_q <= 6'h3f;
			old_q <= 6'h3f;
		end
		else
		begin
			s1_q <= ext_req_n;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			old_q <= lvl_q;
		end
	end

	// Setting and clearing causes for the flags
	assign setup = psel && !penable;
	assign acc = psel && penable && pready;
	assign sel = dec(paddr[21:2]);
	assign wr_acc = acc && pwrite;
	always_comb
	begin
		for (int i = 0; i < `EIRC_N_EXT; i++)
		begin
			set_vec[i] = sense_q[i] ? (old_q[i] && !lvl_q[i]) : !lvl_q[i];
			auto_clr[i] = exc_busy && (exc_src == 4'(i)) && (sense_q[i] || lvl_q[i]);
		end
		sw_clr = (wr_acc && sel == EIRC_SEL_FLAGS) ? (seen_q & ~pwdata[5:0]) : 6'h00;
		clr_vec = auto_clr | sw_clr;
	end

	// Register next values; a set in the same cycle as a clear wins
	always_comb
	begin
		sense_d = sense_q;
		en_d = en_q;
		pa_d = pa_q;
		pb_d = pb_q;
		mask_d = mask_q;
		flag_d = (flag_q & ~clr_vec) | set_vec;
		evt_d = evt_q;
		seen_d = seen_q;
		if (acc && !pwrite && sel == EIRC_SEL_FLAGS)
			seen_d = seen_q | prdata[5:0];
		if (wr_acc)
		begin
			case (sel)
				EIRC_SEL_SENSE: sense_d = pwdata[5:0];
				EIRC_SEL_ENABLE: en_d = pwdata[5:0];
				EIRC_SEL_FLAGS: seen_d = seen_q & pwdata[5:0];
				EIRC_SEL_PRI_A: pa_d = pwdata[7:0];
				EIRC_SEL_PRI_B: pb_d = pwdata[7:0] & `EIRC_PRI_B_BITS;
				EIRC_SEL_EVT: evt_d = evt_q & ~pwdata[5:0];
				EIRC_SEL_MASK: mask_d = pwdata[5:0];
				default: ;
			endcase
		end
		evt_d = evt_d | (set_vec & ~flag_q);
		seen_d = seen_d & flag_d;
		irq_d = |(evt_q & mask_q);
	end

	// APB answer: data captured at setup, ready in the access cycle
	always_comb
	begin
		pready_d = setup;
		pslverr_d = setup && (sel == EIRC_SEL_NONE);
		prdata_d = 32'h0000_0000;
		case (sel)
			EIRC_SEL_SENSE: prdata_d[5:0] = sense_q;
			EIRC_SEL_ENABLE: prdata_d[5:0] = en_q;
			EIRC_SEL_FLAGS: prdata_d[5:0] = flag_q;
			EIRC_SEL_PRI_A: prdata_d[7:0] = pa_q;
			EIRC_SEL_PRI_B: prdata_d[7:0] = pb_q;
			EIRC_SEL_EVT: prdata_d[5:0] = evt_q;
			EIRC_SEL_MASK: prdata_d[5:0] = mask_q;
			default: ;
		endcase
		if (!setup)
			prdata_d = prdata;
	end

	// Choose the lowest id among high-priority pending sources, else among the rest
	always_comb
	begin
		logic found_hi;
		logic found_lo;
		eirc_src_t hi_id;
		eirc_src_t lo_id;
		found_hi = 1'b0;
		found_lo = 1'b0;
		hi_id = 4'h0;
		lo_id = 4'h0;
		pend = {periph_req, flag_q & en_q};
		for (int i = `EIRC_N_SRC - 1; i >= 0; i--)
		begin
			if (pend[i] && pri_of(i, pa_q, pb_q))
			begin
				found_hi = 1'b1;
				hi_id = 4'(i);
			end
			else if (pend[i])
			begin
				found_lo = 1'b1;
				lo_id = 4'(i);
			end
		end
		req_d = found_hi || found_lo;
		hi_d = found_hi;
		src_d = found_hi ? hi_id : lo_id;
	end

	// State registers, all zero after reset
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sense_q <= 6'h00;
			en_q <= 6'h00;
			flag_q <= 6'h00;
			seen_q <= 6'h00;
			evt_q <= 6'h00;
			mask_q <= 6'h00;
			pa_q <= `EIRC_RST8;
			pb_q <= `EIRC_RST8;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			int_req <= 1'b0;
			int_src <= 4'h0;
			int_hi <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			sense_q <= sense_d;
			en_q <= en_d;
			flag_q <= flag_d;
			seen_q <= seen_d;
			evt_q <= evt_d;
			mask_q <= mask_d;
			pa_q <= pa_d;
			pb_q <= pb_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			int_req <= req_d;
			int_src <= src_d;
			int_hi <= hi_d;
			irq <= irq_d;
		end
	end

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	a_level_sets: assert property (!sense_q[1] && !lvl_q[1] |=> flag_q[1])
		else $error("low level input did not set its flag");
	a_edge_sets: assert property (sense_q[0] && $fell(lvl_q[0]) |=> flag_q[0])
		else $error("falling edge did not set its flag");
	a_sw_clear: assert property (1'b1 |=> ((~flag_q & $past(flag_q) & ~$past(clr_vec)) == 6'h00))
		else $error("flag fell without a legal clear");
	a_level_auto: assert property (exc_busy && exc_src == 4'h1 && !sense_q[1]
		&& lvl_q[1] && !set_vec[1] |=> !flag_q[1])
		else $error("level flag not cleared by exception handling");
	a_edge_auto: assert property (exc_busy && exc_src == 4'h0 && sense_q[0]
		&& !set_vec[0] |=> !flag_q[0])
		else $error("edge flag not cleared by exception handling");
	a_write_one: assert property (wr_acc && sel == EIRC_SEL_FLAGS && pwdata[0]
		&& !auto_clr[0] && flag_q[0] |=> flag_q[0])
		else $error("writing one changed a flag");
	a_enable_gate: assert property (flag_q[1] && en_q[1] |=> int_req)
		else $error("enabled flag did not raise a request");
	a_pri_map: assert property (int_req && int_src == 4'h0 |-> int_hi == $past(pa_q[7]))
		else $error("input 0 priority not taken from bit 7 of A");
	a_pri_b_map: assert property (int_req && int_src == 4'ha |-> int_hi == $past(pb_q[7]))
		else $error("8-bit timer 0/1 priority not taken from bit 7 of B");
	a_pri_order: assert property (|(pend[11:10] & pb_q[7:6]) |=> int_hi)
		else $error("high priority source lost to a low one");
	a_irq_out: assert property (|(evt_q & mask_q) |=> irq)
		else $error("unmasked event did not raise the interrupt");

	c_edge_req: cover property (sense_q[0] && $fell(lvl_q[0]) ##1 flag_q[0] ##[1:4] int_req);
	c_auto_clear: cover property (flag_q[1] && auto_clr[1] ##1 !flag_q[1]);
	c_sw_clear: cover property (sw_clr != 6'h00);
	c_hi_wins: cover property (int_req && int_hi && int_src > 4'h5);
endmodule // eirc_top

// ### hw/eirc_params.svh
`ifndef EIRC_PARAMS_SVH
`define EIRC_PARAMS_SVH
// Register indices; byte address is four times the index
`define EIRC_IDX_SENSE 20'hee014
`define EIRC_IDX_ENABLE 20'hee015
`define EIRC_IDX_FLAGS 20'hee016
`define EIRC_IDX_PRI_A 20'hee018
`define EIRC_IDX_PRI_B 20'hee019
`define EIRC_IDX_EVT 20'hee01c
`define EIRC_IDX_MASK 20'hee01d
// Reset values and writable bits
`define EIRC_RST8 8'h00
`define EIRC_EXT_BITS 8'h3f
`define EIRC_PRI_B_BITS 8'hcc
// Source numbering
`define EIRC_N_EXT 6
`define EIRC_N_SRC 14
`endif

// ### hw/eirc_pkg.sv
package eirc_pkg;
	typedef logic [3:0] eirc_src_t;
	typedef logic [5:0] eirc_ext_t;
	typedef logic [7:0] eirc_reg_t;
	typedef logic [13:0] eirc_pend_t;
	// Register selector from the address decoder
	typedef enum logic [2:0] {
		EIRC_SEL_SENSE = 3'h0,
		EIRC_SEL_ENABLE = 3'h1,
		EIRC_SEL_FLAGS = 3'h3,
		EIRC_SEL_PRI_A = 3'h2,
		EIRC_SEL_PRI_B = 3'h6,
		EIRC_SEL_EVT = 3'h7,
		EIRC_SEL_MASK = 3'h5,
		EIRC_SEL_NONE = 3'h4
	} eirc_sel_t;
endpackage

// ### testbench/eirc_core_model.sv
`timescale 1ns/1ps
// Core exception handling: takes a request and runs its handler for four cycles
module eirc_core_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Request from the controller
	input wire logic ack_en,
	input wire logic int_req,
	input wire eirc_pkg::eirc_src_t int_src,
	// Exception handling state
	output logic exc_busy,
	output eirc_pkg::eirc_src_t exc_src
);
	import eirc_pkg::*;
	logic [2:0] cnt_q, cnt_d;
	eirc_src_t src_q, src_d;
	// Accept only when idle, so a handler is never cut short
	always_comb
	begin
		cnt_d = cnt_q;
		src_d = src_q;
		if (cnt_q != 3'h0)
			cnt_d = cnt_q - 3'h1;
		else if (ack_en && int_req)
		begin
			cnt_d = 3'h4;
			src_d = int_src;
		end
	end
	// State registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 3'h0;
			src_q <= 4'h0;
		end
		else
		begin
			cnt_q <= cnt_d;
			src_q <= src_d;
		end
	end
	// Source id is garbage outside a handler, so the design must qualify it
	assign exc_busy = cnt_q != 3'h0;
	assign exc_src = exc_busy ? src_q : ~src_q;
endmodule // eirc_core_model

// ### testbench/external_int_request_ctrl_tb.sv
`timescale 1ns/1ps
`include "eirc_params.svh"
module external_int_request_ctrl_tb;
	import eirc_pkg::*;
	typedef struct {logic [19:0] idx; logic [7:0] wd; logic [7:0] ex; logic er;} eirc_row_t;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, ack_en = 0;
	logic [21:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [5:0] ext_req_n = 6'h3f;
	logic [7:0] periph_req = 8'h00;
	logic exc_busy, int_req, int_hi, irq, er;
	eirc_src_t exc_src, int_src;
	int miscompares = 0, n_checks = 0;
	eirc_row_t rows [6] = '{'{`EIRC_IDX_SENSE, 8'hc1, 8'h01, 1'b0},
		'{`EIRC_IDX_ENABLE, 8'hc0, 8'h00, 1'b0}, '{`EIRC_IDX_PRI_A, 8'ha5, 8'ha5, 1'b0},
		'{`EIRC_IDX_PRI_B, 8'hff, 8'hcc, 1'b0}, '{`EIRC_IDX_MASK, 8'h3f, 8'h3f, 1'b0},
		'{20'hee017, 8'hff, 8'h00, 1'b1}};
	logic [7:0] pa [4] = '{8'h10, 8'h08, 8'h00, 8'h00};
	logic [7:0] pb [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
	logic [4:0] pe [4] = '{5'h15, 5'h16, 5'h1a, 5'h05};
	eirc_top u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_req_n(ext_req_n), .periph_req(periph_req), .exc_busy(exc_busy),
		.exc_src(exc_src), .int_req(int_req), .int_src(int_src), .int_hi(int_hi), .irq(irq));
	eirc_core_model u_core (.clk(clk), .nrst(nrst), .ack_en(ack_en), .int_req(int_req),
		.int_src(int_src), .exc_busy(exc_busy), .exc_src(exc_src));
	// 25 MHz clock
	always #20 clk = ~clk;
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; pready sampled at the rising edge, data taken at that same edge
	task apb(input logic w, input logic [19:0] idx, input logic [7:0] wd,
		output logic [31:0] d, output logic e);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			miscompares++;
			end_of_test();
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [19:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd, rd, er);
	endtask
	task rdc(input logic [19:0] idx, input logic [7:0] ex);
		apb(1'b0, idx, 8'h00, rd, er);
		chk(rd, {24'h0, ex});
	endtask
	// Pin change at a rising edge, then time for the pin filter
	task pin(input int n, input logic v, input int w);
		@(posedge clk);
		ext_req_n[n] <= v;
		cyc(w);
	endtask
	initial
	begin
		cyc(20);
		nrst <= 1'b1;
		cyc(4);
		// Reset values, write masks and unmapped address
		foreach (rows[k])
		begin
			rdc(rows[k].idx, 8'h00);
			wr(rows[k].idx, rows[k].wd);
			apb(1'b0, rows[k].idx, 8'h00, rd, er);
			chk(rd, {24'h0, rows[k].ex});
			chk(er, rows[k].er);
		end
		// Edge flag, gated request, clear only after read-as-1
		pin(0, 1'b0, 8);
		rdc(`EIRC_IDX_FLAGS, 8'h01);
		chk(int_req, 1'b0);
		chk(irq, 1'b1);
		wr(`EIRC_IDX_FLAGS, 8'h3f);
		rdc(`EIRC_IDX_FLAGS, 8'h01);
		wr(`EIRC_IDX_FLAGS, 8'h3e);
		rdc(`EIRC_IDX_FLAGS, 8'h00);
		wr(`EIRC_IDX_EVT, 8'h01);
		cyc(3);
		chk(irq, 1'b0);
		// Masked event; a blind write of 0 must not clear
		wr(`EIRC_IDX_MASK, 8'h00);
		pin(0, 1'b1, 8);
		pin(0, 1'b0, 8);
		cyc(1);
		chk(irq, 1'b0);
		wr(`EIRC_IDX_FLAGS, 8'h00);
		rdc(`EIRC_IDX_FLAGS, 8'h01);
		rdc(`EIRC_IDX_EVT, 8'h01);
		wr(`EIRC_IDX_EVT, 8'h01);
		// Level input held low keeps its flag and raises the request
		pin(1, 1'b0, 8);
		rdc(`EIRC_IDX_FLAGS, 8'h03);
		wr(`EIRC_IDX_FLAGS, 8'h3c);
		rdc(`EIRC_IDX_FLAGS, 8'h02);
		wr(`EIRC_IDX_ENABLE, 8'h02);
		cyc(4);
		chk({int_req, int_src}, 5'h11);
		// Exception handling clears the level flag only once the pin is high
		ack_en <= 1'b1;
		cyc(20);
		rdc(`EIRC_IDX_FLAGS, 8'h02);
		pin(1, 1'b1, 20);
		rdc(`EIRC_IDX_FLAGS, 8'h00);
		chk(int_req, 1'b0);
		// Edge flag cleared by its handler although the pin stays low
		wr(`EIRC_IDX_ENABLE, 8'h01);
		pin(0, 1'b1, 8);
		pin(0, 1'b0, 20);
		rdc(`EIRC_IDX_FLAGS, 8'h00);
		// Priority classes against peripheral sources 6 and 10
		ack_en <= 1'b0;
		wr(`EIRC_IDX_ENABLE, 8'h20);
		periph_req <= 8'h11;
		pin(5, 1'b0, 8);
		foreach (pa[k])
		begin
			wr(`EIRC_IDX_PRI_A, pa[k]);
			wr(`EIRC_IDX_PRI_B, pb[k]);
			cyc(4);
			chk({int_hi, int_src}, pe[k]);
		end
		// Reset in mid-run: enables and sense go back to zero, no request
		periph_req <= 8'h00;
		nrst <= 1'b0;
		cyc(2);
		chk(int_req, 1'b0);
		nrst <= 1'b1;
		cyc(4);
		rdc(`EIRC_IDX_ENABLE, 8'h00);
		rdc(`EIRC_IDX_SENSE, 8'h00);
		chk(int_req, 1'b0);
		end_of_test();
	end
endmodule // external_int_request_ctrl_tb
